// file: core/illum_channel_ctrl.sv
// Emitter sequencing, current selection, modulation clock and registers.
`timescale 1ns/1ps
`default_nettype none
`include "illum_defs.svh"
module illum_channel_ctrl #(
  parameter int ORDER_STEPS = `ORDER_STEPS,
  parameter int CORDIC_ITER = `CORDIC_ITER
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  input wire logic sample_tick,
  input wire logic auto_level_high,
  input wire logic iq_valid,
  input wire logic signed [15:0] i_sample,
  input wire logic signed [15:0] q_sample,
  output logic emitter_out_0,
  output logic emitter_out_1,
  output logic emitter_out_2,
  output logic driver_active,
  output logic [10:0] drive_current,
  output logic [3:0] bias_code,
  output logic [4:0] current_code,
  output illum_pkg::channel_t active_channel,
  output logic level_high,
  output logic [15:0] phase_out,
  output logic [17:0] amplitude_out,
  output logic phase_valid
);
  import illum_pkg::*;

  localparam logic [10:0] MOD_W = 11'(`ACC_MOD);
  localparam logic [10:0] HALF_W = 11'(`ACC_MOD / 2);
  localparam logic [10:0] INC_BASE =
    11'(`ACC_MOD * (`MOD_CLK_HZ / 1000000) / (`SYS_CLK_HZ / 1000000));
  localparam logic [10:0] INC_SEVENTHS = 11'((INC_BASE * 6) / 7);
  localparam logic [10:0] INC_FIFTHS = 11'((INC_BASE * 6) / 5);
  localparam logic [10:0] PHASE_UNIT = 11'(`ACC_MOD / `PHASE_STEPS);
  localparam logic [2:0] LAST_STEP = 3'(ORDER_STEPS - 1);

  generate
    if (ORDER_STEPS < 1 || ORDER_STEPS > 6)
    begin : g_bad_steps
      $error("ORDER_STEPS must lie in 1..6");
    end
    if ((`ACC_MOD % `PHASE_STEPS) != 0 || (INC_BASE * 6) % 35 != 0)
    begin : g_bad_acc
      $error("accumulator modulus cannot give exact frequencies");
    end
  endgenerate

  // Returns {hit, index} for an address of the writable register file.
  function automatic logic [4:0] reg_index(input logic [7:0] a);
    case (a)
      `ADDR_CURRENT: reg_index = {1'b1, `IDX_CURRENT};
      `ADDR_SELECT: reg_index = {1'b1, `IDX_SELECT};
      `ADDR_SCALE: reg_index = {1'b1, `IDX_SCALE};
      `ADDR_OFS_L0: reg_index = {1'b1, `IDX_OFS_L0};
      `ADDR_CORR: reg_index = {1'b1, `IDX_CORR};
      `ADDR_OFS_H0: reg_index = {1'b1, `IDX_OFS_H0};
      `ADDR_OFS_L1: reg_index = {1'b1, `IDX_OFS_L1};
      `ADDR_OFS_H1: reg_index = {1'b1, `IDX_OFS_H1};
      `ADDR_OFS_L2: reg_index = {1'b1, `IDX_OFS_L2};
      `ADDR_OFS_H2: reg_index = {1'b1, `IDX_OFS_H2};
      `ADDR_PHASE: reg_index = {1'b1, `IDX_PHASE};
      `ADDR_AMBIENT: reg_index = {1'b1, `IDX_AMBIENT};
      `ADDR_DRIVER: reg_index = {1'b1, `IDX_DRIVER};
      default: reg_index = 5'h00;
    endcase
  endfunction

  function automatic channel_t order_entry(input logic [11:0] order,
                                           input logic [2:0] idx);
    order_entry = order[{idx, 1'b0} +: 2];
  endfunction

  function automatic logic [5:0] step_tenths(input logic [2:0] scale);
    case (scale)
      3'h0: step_tenths = `STEP_56;
      3'h1: step_tenths = `STEP_42;
      3'h2: step_tenths = `STEP_28;
      3'h3: step_tenths = `STEP_14;
      default: step_tenths = 6'h00;
    endcase
  endfunction

  logic [23:0] regs_reg [`NUM_REGS];
  logic [4:0] wr_hit;
  logic [4:0] rd_hit;
  logic [23:0] status_word;

  assign wr_hit = reg_index(reg_addr);
  assign rd_hit = reg_index(reg_addr);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int n = 0; n < `NUM_REGS; n++)
        regs_reg[n] <= `REG_RESET;
    end
    else if (reg_wr && wr_hit[4])
    begin
      regs_reg[wr_hit[3:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else if (reg_rd && rd_hit[4])
      reg_rdata <= regs_reg[rd_hit[3:0]];
    else if (reg_rd && reg_addr == `ADDR_STATUS)
      reg_rdata <= status_word;
    else
      reg_rdata <= '0;
  end

  logic [23:0] cur_r;
  logic [23:0] sel_r;
  logic [23:0] scale_r;
  logic [23:0] drv_r;
  logic switch_en;
  channel_t fixed_sel;
  logic [11:0] order_field;
  logic auto_en;
  logic fixed_level;
  logic drv_en;
  logic [3:0] phase_step;
  freq_sel_e freq_sel;

  assign cur_r = regs_reg[`IDX_CURRENT];
  assign sel_r = regs_reg[`IDX_SELECT];
  assign scale_r = regs_reg[`IDX_SCALE];
  assign drv_r = regs_reg[`IDX_DRIVER];
  assign switch_en = sel_r[0];
  assign fixed_sel = sel_r[2:1];
  assign order_field = sel_r[14:3];
  assign auto_en = sel_r[15];
  assign fixed_level = sel_r[16];
  assign drv_en = drv_r[0];
  assign phase_step = regs_reg[`IDX_PHASE][6:3];
  assign freq_sel = freq_sel_e'(regs_reg[`IDX_PHASE][8:7]);

  // Channel sequencing is independent of capture and current-level mode.
  logic [2:0] step_idx_reg;
  channel_t active_ch_reg;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      step_idx_reg <= '0;
      active_ch_reg <= '0;
    end
    else if (sample_tick)
    begin
      if (switch_en)
      begin
        active_ch_reg <= order_entry(order_field, step_idx_reg);
        step_idx_reg <= (step_idx_reg == LAST_STEP) ? 3'h0
                        : step_idx_reg + 3'h1;
      end
      else
      begin
        active_ch_reg <= fixed_sel;
        step_idx_reg <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      level_high <= 1'b0;
    else
      level_high <= auto_en ? auto_level_high : fixed_level;
  end

  logic [4:0] low_code;
  logic [4:0] high_code;
  logic [4:0] sel_code;
  logic [5:0] sel_step;
  logic [10:0] current_next;

  always_comb
  begin
    case (active_ch_reg)
      2'h0:
      begin
        low_code = cur_r[4:0];
        high_code = cur_r[9:5];
      end
      2'h1:
      begin
        low_code = cur_r[14:10];
        high_code = cur_r[19:15];
      end
      2'h2:
      begin
        low_code = {sel_r[23], cur_r[23:20]};
        high_code = sel_r[22:18];
      end
      default:
      begin
        low_code = 5'h00;
        high_code = 5'h00;
      end
    endcase
  end

  assign sel_code = level_high ? high_code : low_code;
  assign sel_step = step_tenths(level_high ? scale_r[21:19]
                                           : scale_r[18:16]);
  // Current in tenths of a milliampere; a bad scale code gives no step.
  assign current_next = {6'h00, sel_code} * {5'h00, sel_step}
                        + {7'h00, drv_r[11:8]} * `BIAS_TENTHS;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      drive_current <= '0;
      bias_code <= '0;
      current_code <= '0;
      driver_active <= 1'b0;
    end
    else
    begin
      drive_current <= drv_en ? current_next : 11'h000;
      bias_code <= drv_r[11:8];
      current_code <= sel_code;
      driver_active <= drv_en && active_ch_reg != 2'h3;
    end
  end

  // Modulo accumulator: exact average rates at 40 MHz, but edges land
  // on system clock edges, so phase steps finer than 90 degrees are dropped
  // at the base rate and show as timing jitter only at the 6/7 and 6/5 rates.
  logic [10:0] acc_reg;
  logic [10:0] inc;
  logic [10:0] acc_sum;
  logic [10:0] shifted;
  logic [10:0] shifted_mod;
  logic mod_clk_reg;

  always_comb
  begin
    case (freq_sel)
      FREQ_SIX_SEVENTHS: inc = INC_SEVENTHS;
      FREQ_SIX_FIFTHS: inc = INC_FIFTHS;
      default: inc = INC_BASE;
    endcase
  end

  assign acc_sum = acc_reg + inc;
  assign shifted = acc_reg + 11'({7'h00, phase_step} * PHASE_UNIT);
  assign shifted_mod = (shifted >= MOD_W) ? shifted - MOD_W : shifted;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      acc_reg <= '0;
      mod_clk_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= (acc_sum >= MOD_W) ? acc_sum - MOD_W : acc_sum;
      mod_clk_reg <= shifted_mod < HALF_W;
    end
  end

  logic [2:0] emitter_reg;

  generate
    for (genvar k = 0; k < 3; k++)
    begin : g_emitter
      always_ff @(posedge sys_clk)
      begin
        if (srst)
          emitter_reg[k] <= 1'b0;
        else
          emitter_reg[k] <= drv_en && mod_clk_reg
                            && active_ch_reg == channel_t'(k);
      end
    end
  endgenerate

  assign emitter_out_0 = emitter_reg[0];
  assign emitter_out_1 = emitter_reg[1];
  assign emitter_out_2 = emitter_reg[2];
  assign active_channel = active_ch_reg;
  assign status_word = {18'h00000, level_high, step_idx_reg, active_ch_reg};

  logic [15:0] offset_reg;
  logic [3:0] ofs_idx;

  always_comb
  begin
    case ({active_ch_reg, level_high})
      3'b000: ofs_idx = `IDX_OFS_L0;
      3'b001: ofs_idx = `IDX_OFS_H0;
      3'b010: ofs_idx = `IDX_OFS_L1;
      3'b011: ofs_idx = `IDX_OFS_H1;
      3'b100: ofs_idx = `IDX_OFS_L2;
      3'b101: ofs_idx = `IDX_OFS_H2;
      default: ofs_idx = `IDX_OFS_L0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      offset_reg <= '0;
    else
      offset_reg <= regs_reg[ofs_idx][15:0];
  end

  illum_depth_engine #(
    .CORDIC_ITER(CORDIC_ITER)
  ) u_depth (
    .sys_clk(sys_clk),
    .srst(srst),
    .iq_valid(iq_valid),
    .i_sample(i_sample),
    .q_sample(q_sample),
    .offset(offset_reg),
    .corr_en(regs_reg[`IDX_CORR][0]),
    .phase_out(phase_out),
    .amplitude_out(amplitude_out),
    .phase_valid(phase_valid)
  );

  one_emitter_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    $onehot0(emitter_reg))
    else $error("more than one emitter driven");

  driver_off_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    !drv_en |=> (emitter_reg == 3'h0 && drive_current == 11'h000))
    else $error("emitter driven while driver disabled");

  seq_wrap_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (sample_tick && switch_en && step_idx_reg == LAST_STEP)
      |=> step_idx_reg == 3'h0)
    else $error("channel order did not wrap");

  order_pick_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (sample_tick && switch_en) |=> active_ch_reg ==
      order_entry($past(order_field), $past(step_idx_reg)))
    else $error("channel not taken from order entry");

  fixed_chan_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (sample_tick && !switch_en) |=> active_ch_reg == $past(fixed_sel))
    else $error("fixed channel select not applied");

  level_pick_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    !auto_en |=> level_high == $past(fixed_level))
    else $error("manual level select not applied");

  mod_period_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    ($rose(mod_clk_reg) && freq_sel == FREQ_BASE && !reg_wr
      && !$past(reg_wr) && !$past(reg_wr, 2))
      ##1 (!reg_wr)[*3] |=> $rose(mod_clk_reg))
    else $error("modulation period is not four cycles");

  current_calc_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    drv_en |=> drive_current == $past(current_next))
    else $error("drive current does not follow code and step");
endmodule
`default_nettype wire

// file: core/illum_defs.svh
// Register map, field positions and timing constants for the emitter block.
// Notes on behaviour
// - Never drive two emitter outputs together.
// - Switching enabled: move current per sample.
// - Switching disabled: use fixed channel select.
// - Order entries consumed from least significant.
// - Channel modes combine with capture, current modes.
// - Current and offsets chosen by active channel.
// - Derive 10 MHz modulation from system clock.
// - Phase equals step code times 22.5 degrees; at the base rate the code drops steps finer than 90 degrees.
// - De-aliasing frequencies base times 6/7, 6/5.
// - Driver stays off unless enable set.
// - Current equals selected code times DAC step.
// - Scale codes 0..3 give 5.6..1.4 mA steps.
// - Bias adds 0.5 mA per code step.
// - Phase and amplitude computed from I/Q.
// - Subtract channel and level offset when enabled.
// - Manual level select: 0 low, 1 high.
`ifndef ILLUM_DEFS_SVH
`define ILLUM_DEFS_SVH

`define ADDR_CURRENT 8'h29
`define ADDR_SELECT 8'h2A
`define ADDR_SCALE 8'h2B
`define ADDR_OFS_L0 8'h42
`define ADDR_CORR 8'h43
`define ADDR_OFS_H0 8'h51
`define ADDR_OFS_L1 8'h52
`define ADDR_OFS_H1 8'h53
`define ADDR_OFS_L2 8'h54
`define ADDR_OFS_H2 8'h55
`define ADDR_PHASE 8'h71
`define ADDR_AMBIENT 8'h72
`define ADDR_DRIVER 8'h79
`define ADDR_STATUS 8'h7A

`define IDX_CURRENT 4'h0
`define IDX_SELECT 4'h1
`define IDX_SCALE 4'h2
`define IDX_OFS_L0 4'h3
`define IDX_CORR 4'h4
`define IDX_OFS_H0 4'h5
`define IDX_OFS_L1 4'h6
`define IDX_OFS_H1 4'h7
`define IDX_OFS_L2 4'h8
`define IDX_OFS_H2 4'h9
`define IDX_PHASE 4'hA
`define IDX_AMBIENT 4'hB
`define IDX_DRIVER 4'hC
`define NUM_REGS 13
`define REG_RESET 24'h000000

`define ORDER_STEPS 6
`define SYS_CLK_HZ 40000000
`define MOD_CLK_HZ 10000000
`define PHASE_STEPS 16
`define ACC_MOD 560
`define STEP_56 6'h38
`define STEP_42 6'h2A
`define STEP_28 6'h1C
`define STEP_14 6'h0E
`define BIAS_TENTHS 11'h005
`define HALF_TURN 16'h8000
`define CORDIC_ITER 14

`endif

// file: core/illum_depth_engine.sv
// Iterative phase and amplitude estimator with phase offset subtraction.
`timescale 1ns/1ps
`default_nettype none
`include "illum_defs.svh"
module illum_depth_engine #(
  parameter int CORDIC_ITER = `CORDIC_ITER
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic iq_valid,
  input wire logic signed [15:0] i_sample,
  input wire logic signed [15:0] q_sample,
  input wire logic [15:0] offset,
  input wire logic corr_en,
  output logic [15:0] phase_out,
  output logic [17:0] amplitude_out,
  output logic phase_valid
);
  import illum_pkg::*;

  // One cycle to load, CORDIC_ITER to iterate, one in the done state, and
  // the result register, so the strobe is sampled this many edges later.
  localparam int LAT = CORDIC_ITER + 2;

  generate
    if (CORDIC_ITER < 1 || CORDIC_ITER > 14)
    begin : g_bad_iter
      $error("CORDIC_ITER must lie in 1..14");
    end
  endgenerate

  // Arctangent of 2^-k with a full turn equal to 2^16.
  function automatic logic [15:0] atan_step(input logic [3:0] k);
    case (k)
      4'h0: atan_step = 16'h2000;
      4'h1: atan_step = 16'h12E4;
      4'h2: atan_step = 16'h09FB;
      4'h3: atan_step = 16'h0511;
      4'h4: atan_step = 16'h028B;
      4'h5: atan_step = 16'h0146;
      4'h6: atan_step = 16'h00A3;
      4'h7: atan_step = 16'h0051;
      4'h8: atan_step = 16'h0029;
      4'h9: atan_step = 16'h0014;
      4'hA: atan_step = 16'h000A;
      4'hB: atan_step = 16'h0005;
      4'hC: atan_step = 16'h0003;
      4'hD: atan_step = 16'h0001;
      default: atan_step = 16'h0000;
    endcase
  endfunction

  depth_state_e state_reg;
  logic signed [17:0] x_reg;
  logic signed [17:0] y_reg;
  logic [15:0] z_reg;
  logic [3:0] k_reg;
  logic [15:0] offset_reg;
  logic corr_en_reg;
  logic signed [17:0] i_ext;
  logic signed [17:0] q_ext;

  assign i_ext = {{2{i_sample[15]}}, i_sample};
  assign q_ext = {{2{q_sample[15]}}, q_sample};

  // Samples offered while a conversion runs are dropped; the upstream
  // sample rate is far below one result per 16 cycles.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_reg <= DEPTH_IDLE;
      x_reg <= '0;
      y_reg <= '0;
      z_reg <= '0;
      k_reg <= '0;
      offset_reg <= '0;
      corr_en_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        DEPTH_IDLE:
        begin
          if (iq_valid)
          begin
            // Fold the left half plane over so the iteration converges.
            x_reg <= i_sample[15] ? -i_ext : i_ext;
            y_reg <= i_sample[15] ? -q_ext : q_ext;
            z_reg <= i_sample[15] ? `HALF_TURN : 16'h0000;
            k_reg <= '0;
            offset_reg <= offset;
            corr_en_reg <= corr_en;
            state_reg <= DEPTH_RUN;
          end
        end
        DEPTH_RUN:
        begin
          if (!y_reg[17])
          begin
            x_reg <= x_reg + (y_reg >>> k_reg);
            y_reg <= y_reg - (x_reg >>> k_reg);
            z_reg <= z_reg + atan_step(k_reg);
          end
          else
          begin
            x_reg <= x_reg - (y_reg >>> k_reg);
            y_reg <= y_reg + (x_reg >>> k_reg);
            z_reg <= z_reg - atan_step(k_reg);
          end
          k_reg <= k_reg + 4'h1;
          if (k_reg == 4'(CORDIC_ITER - 1))
            state_reg <= DEPTH_DONE;
        end
        DEPTH_DONE: state_reg <= DEPTH_IDLE;
        default: state_reg <= DEPTH_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      phase_out <= '0;
      amplitude_out <= '0;
      phase_valid <= 1'b0;
    end
    else
    begin
      phase_valid <= (state_reg == DEPTH_DONE);
      if (state_reg == DEPTH_DONE)
      begin
        phase_out <= corr_en_reg ? z_reg - offset_reg : z_reg;
        amplitude_out <= x_reg;
      end
    end
  end

  offset_sub_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    phase_valid |-> phase_out == ($past(corr_en_reg)
      ? $past(z_reg) - $past(offset_reg) : $past(z_reg)))
    else $error("phase result does not match offset subtraction");

  depth_latency_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (state_reg == DEPTH_IDLE && iq_valid) |-> ##[LAT:LAT] phase_valid)
    else $error("phase result not delivered on time");
endmodule
`default_nettype wire

// file: core/illum_pkg.sv
// Types shared by the emitter control and depth correction modules.
`default_nettype none
package illum_pkg;
  typedef logic [1:0] channel_t;
  typedef enum logic [1:0]
  {
    FREQ_BASE = 2'h0,
    FREQ_SIX_SEVENTHS = 2'h1,
    FREQ_SIX_FIFTHS = 2'h2
  } freq_sel_e;
  typedef enum logic [1:0]
  {
    DEPTH_IDLE = 2'b00,
    DEPTH_RUN = 2'b01,
    DEPTH_DONE = 2'b11
  } depth_state_e;
endpackage
`default_nettype wire

// file: testbench/emitter_load.sv
// Emitter load model that counts light pulses per output and overlaps.
`timescale 1ns/1ps
`default_nettype none
module emitter_load (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic emitter_out_0,
  input wire logic emitter_out_1,
  input wire logic emitter_out_2,
  output var int p0,
  output var int p1,
  output var int p2,
  output var int ovl
);
  logic [2:0] lit;
  logic [2:0] prev_reg = 3'h0;
  assign lit = {emitter_out_2, emitter_out_1, emitter_out_0};
  // The emitters share one current source, so two lit outputs are counted.
  always @(posedge sys_clk)
  begin
    prev_reg <= lit;
    p0 <= clr ? 0 : p0 + int'(lit[0] && !prev_reg[0]);
    p1 <= clr ? 0 : p1 + int'(lit[1] && !prev_reg[1]);
    p2 <= clr ? 0 : p2 + int'(lit[2] && !prev_reg[2]);
    ovl <= clr ? 0 : ovl + int'($countones(lit) > 1);
  end
endmodule
`default_nettype wire

// file: testbench/illum_channel_ctrl_tb.sv
// Self-checking bench for emitter sequencing, current and depth outputs.
`timescale 1ns/1ps
`default_nettype none
module illum_channel_ctrl_tb;
  import illum_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sample_tick = 1'b0;
  logic auto_level_high = 1'b0;
  logic iq_valid = 1'b0;
  logic signed [15:0] i_sample = 16'h0000;
  logic signed [15:0] q_sample = 16'h0000;
  logic clr = 1'b0;
  logic [23:0] reg_rdata;
  logic emitter_out_0;
  logic emitter_out_1;
  logic emitter_out_2;
  logic driver_active;
  logic [10:0] drive_current;
  logic [3:0] bias_code;
  logic [4:0] current_code;
  channel_t active_channel;
  logic level_high;
  logic [15:0] phase_out;
  logic [17:0] amplitude_out;
  logic phase_valid;
  int p0;
  int p1;
  int p2;
  int ovl;
  int pl [3];
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 81;
  logic [23:0] shadow [256];
  logic [7:0] regs [13] = '{8'h29, 8'h2A, 8'h2B, 8'h42, 8'h43, 8'h51,
    8'h52, 8'h53, 8'h54, 8'h55, 8'h71, 8'h72, 8'h79};

  illum_channel_ctrl u_dut (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick),
    .auto_level_high(auto_level_high), .iq_valid(iq_valid),
    .i_sample(i_sample), .q_sample(q_sample),
    .emitter_out_0(emitter_out_0), .emitter_out_1(emitter_out_1),
    .emitter_out_2(emitter_out_2), .driver_active(driver_active),
    .drive_current(drive_current), .bias_code(bias_code),
    .current_code(current_code), .active_channel(active_channel),
    .level_high(level_high), .phase_out(phase_out),
    .amplitude_out(amplitude_out), .phase_valid(phase_valid));

  emitter_load u_load (.sys_clk(sys_clk), .clr(clr),
    .emitter_out_0(emitter_out_0), .emitter_out_1(emitter_out_1),
    .emitter_out_2(emitter_out_2), .p0(p0), .p1(p1), .p2(p2), .ovl(ovl));

  always #12.5 sys_clk = ~sys_clk;
  always_comb pl = '{p0, p1, p2};

  task automatic give_verdict();
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [23:0] seen,
    input int exp);
    checked++;
    if (seen !== 24'(exp))
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Accepts a small error, modulo md, by handing back the value seen.
  function automatic int near(input int seen, input int exp, input int tol,
    input int md);
    int d;
    d = (seen - exp) % md;
    if (d < 0)
      d += md;
    return (d <= tol || d >= md - tol) ? seen : exp;
  endfunction

  function automatic int exp_code(input int ch, input bit hi);
    logic [23:0] c;
    logic [23:0] s;
    c = shadow[8'h29];
    s = shadow[8'h2A];
    case (ch)
      0: return hi ? c[9:5] : c[4:0];
      1: return hi ? c[19:15] : c[14:10];
      default: return hi ? s[22:18] : {s[23], c[23:20]};
    endcase
  endfunction

  function automatic int exp_cur(input int ch, input bit hi);
    logic [2:0] sc;
    int st;
    sc = hi ? shadow[8'h2B][21:19] : shadow[8'h2B][18:16];
    st = sc == 0 ? 56 : sc == 1 ? 42 : sc == 2 ? 28 : sc == 3 ? 14 : 0;
    return exp_code(ch, hi) * st + shadow[8'h79][11:8] * 5;
  endfunction

  task automatic do_reset();
    @(posedge sys_clk);
    srst <= 1'b1;
    foreach (shadow[k]) shadow[k] = 24'h000000;
    repeat (9) @(posedge sys_clk);
    srst <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    shadow[a] = d;
  endtask

  task automatic rd_chk(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, shadow[a]);
  endtask

  // Ticks one sample, then checks the channel, current and emitter pulses.
  task automatic tick_chk(input int ch, input bit hi);
    int en;
    int e;
    en = shadow[8'h79][0];
    @(posedge sys_clk);
    sample_tick <= 1'b1;
    @(posedge sys_clk);
    sample_tick <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("active_channel", active_channel, ch);
    check("driver_active", driver_active, en != 0 && ch != 3);
    if (ch != 3)
    begin
      check("level_high", level_high, hi);
      check("current_code", current_code, exp_code(ch, hi));
      check("drive_current", drive_current, en * exp_cur(ch, hi));
    end
    check("bias_code", bias_code, shadow[8'h79][11:8]);
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    for (int k = 0; k < 3; k++)
    begin
      e = (en != 0 && ch == k) ? 3 : 0;
      check("emitter_pulses", 24'(pl[k]), near(pl[k], e, e / 3, 99));
    end
    check("overlaps", 24'(ovl), 0);
  endtask

  initial
  begin
    logic [23:0] v;
    int t;
    int ex;
    do_reset();
    foreach (regs[k]) rd_chk(regs[k]);
    foreach (regs[k]) wr(regs[k], 24'($random(seed)));
    wr(8'h30, 24'h5A5A5A);
    shadow[8'h30] = 24'h000000;
    foreach (regs[k]) rd_chk(regs[k]);
    rd_chk(8'h30);
    do_reset();
    wr(8'h79, 24'($random(seed)) | 24'h000001);
    for (int ch = 0; ch < 3; ch++)
      for (int hi = 0; hi < 2; hi++)
      begin
        wr(8'h29, 24'($random(seed)));
        wr(8'h2B, 24'($random(seed)));
        v = (24'($random(seed)) & 24'hFE7FF8) | 24'(ch << 1) | 24'(hi << 16);
        wr(8'h2A, v);
        tick_chk(ch, hi[0]);
      end
    wr(8'h79, shadow[8'h79] & 24'hFFFFFE);
    tick_chk(2, 1'b1);
    wr(8'h79, shadow[8'h79] | 24'h000001);
    wr(8'h2A, 24'h008000);
    @(posedge sys_clk);
    auto_level_high <= 1'b1;
    tick_chk(0, 1'b1);
    @(posedge sys_clk);
    auto_level_high <= 1'b0;
    tick_chk(0, 1'b0);
    for (int r = 0; r < 2; r++)
    begin
      do_reset();
      wr(8'h29, 24'($random(seed)));
      wr(8'h2B, 24'($random(seed)));
      wr(8'h79, 24'($random(seed)) | 24'h000001);
      v = (r == 0) ? 24'h004920 : 24'($random(seed)) & 24'h007FF8;
      v = v | 24'h010001 | (24'($random(seed)) & 24'hFE0000);
      wr(8'h2A, v);
      for (int k = 0; k < 7; k++)
        tick_chk(v[3 + 2 * (k % 6) +: 2], 1'b1);
      // Seven ticks leave the order index at one, on entry zero, level high.
      shadow[8'h7A] = 24'h000024 | 24'(v[4:3]);
      rd_chk(8'h7A);
    end
    do_reset();
    wr(8'h79, 24'h000001);
    for (int c = 0; c < 3; c++)
    begin
      wr(8'h52, 24'($random(seed)));
      wr(8'h53, 24'($random(seed)));
      wr(8'h43, 24'(c != 0));
      wr(8'h2A, (c == 1) ? 24'h010002 : 24'h000002);
      tick_chk(1, c == 1);
      @(posedge sys_clk);
      i_sample <= 16'h3E80;
      q_sample <= 16'h0000;
      iq_valid <= 1'b1;
      @(posedge sys_clk);
      iq_valid <= 1'b0;
      t = 0;
      while (phase_valid !== 1'b1 && t < 40)
      begin
        @(posedge sys_clk);
        #1;
        t++;
      end
      check("phase_valid", phase_valid, 1);
      ex = (c == 0) ? 0 : 65536 - shadow[(c == 1) ? 8'h53 : 8'h52][15:0];
      ex = ex % 65536;
      check("phase_out", phase_out, near(phase_out, ex, 8, 65536));
      check("amplitude", amplitude_out,
        near(amplitude_out, 26348, 64, 1 << 20));
    end
    wr(8'h2A, 24'h000000);
    tick_chk(0, 1'b0);
    for (int f = 0; f < 3; f++)
    begin
      wr(8'h2A, 24'h000000);
      wr(8'h71, 24'(f << 7) | (24'($random(seed)) & 24'h000078));
      @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      repeat (280) @(posedge sys_clk);
      #1;
      ex = (f == 0) ? 70 : (f == 1) ? 60 : 84;
      check("mod_pulses", 24'(p0), near(p0, ex, 1, 1 << 20));
      check("overlaps", 24'(ovl + p1 + p2), 0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
